// >>> pkg/lchp_defs.svh
`ifndef LCHP_DEFS_SVH
`define LCHP_DEFS_SVH
// Software register offsets (byte addresses, one word each)
`define LCHP_REG_CTRL 4'h0
`define LCHP_REG_ADDR 4'h4
`define LCHP_REG_WDATA 4'h8
`define LCHP_REG_STATUS 4'hC
// Control fields
`define LCHP_CTRL_GO 0
`define LCHP_CTRL_READ 1
`define LCHP_CTRL_LO 2
`define LCHP_CTRL_HI 3
`define LCHP_CTRL_SHARED 4
`define LCHP_CTRL_BIGEND 5
// Status fields
`define LCHP_STAT_BUSY 0
`define LCHP_STAT_DONE 1
`define LCHP_STAT_BADADR 2
`define LCHP_STAT_TMO 3
// Device window
`define LCHP_MEM_TOP 17'h1_3FFF
`define LCHP_REG_BASE 17'h1_FFE0
// Timing in ns and in cycles at 100 ns
`define LCHP_CLK_NS 100
`define LCHP_SETUP_NS 200
`define LCHP_SETUP_CYC ((`LCHP_SETUP_NS + `LCHP_CLK_NS - 1) / `LCHP_CLK_NS)
`define LCHP_RECOV_NS 200
`define LCHP_RECOV_CYC ((`LCHP_RECOV_NS + `LCHP_CLK_NS - 1) / `LCHP_CLK_NS)
`define LCHP_TMO_CYC 16'h0_FFF
`define LCHP_STRAP_CYC 4'h4
`endif

// >>> pkg/lchp_pkg.sv
package lchp_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD,
      ST_RECOV
   } lchp_state_e;
   typedef logic [16:0] lchp_addr_t;
   typedef logic [15:0] lchp_data_t;
endpackage

// >>> src/lchp_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Three-stage synchroniser; output changes once stages two and three agree
module lchp_sync (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire logic d_in,
   input wire logic init_in,
   output logic q_out
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
      end else if (ce_in) begin
         s1_ff <= d_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q_out <= 1'b1;
      end else if (ce_in && (s2_ff == s3_ff)) begin
         q_out <= s3_ff;
      end
   end
   logic unused;
   assign unused = init_in;
endmodule
`default_nettype wire

// >>> src/lchp_avs.sv
`timescale 1ns/10ps
`default_nettype none
`include "lchp_defs.svh"
// Avalon-MM slave holding control, address and write data registers
module lchp_avs (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire logic [3:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [31:0] writedata_in,
   output logic [31:0] readdata_out,
   output logic waitrequest_out,
   input wire logic [31:0] status_in,
   output logic [5:0] ctrl_out,
   output logic go_out,
   output logic [16:0] addr_out,
   output logic [15:0] wdata_out
);
   logic rd_done_ff;
   logic [31:0] nxt_rdata;
   // One wait cycle on reads so readdata comes from a flop
   assign waitrequest_out = read_in && !rd_done_ff;
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (address_in == `LCHP_REG_CTRL) begin
         nxt_rdata = {26'h000_0000, ctrl_out};
      end else if (address_in == `LCHP_REG_ADDR) begin
         nxt_rdata = {15'h0000, addr_out};
      end else if (address_in == `LCHP_REG_WDATA) begin
         nxt_rdata = {16'h0000, wdata_out};
      end else if (address_in == `LCHP_REG_STATUS) begin
         nxt_rdata = status_in;
      end
   end
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_done_ff <= 1'b0;
         readdata_out <= 32'h0000_0000;
      end else if (ce_in) begin
         rd_done_ff <= read_in && !rd_done_ff;
         if (read_in && !rd_done_ff) begin
            readdata_out <= nxt_rdata;
         end
      end
   end
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl_out <= 6'h00;
         go_out <= 1'b0;
         addr_out <= 17'h0_0000;
         wdata_out <= 16'h0000;
      end else if (ce_in) begin
         go_out <= 1'b0;
         if (write_in) begin
            if (address_in == `LCHP_REG_CTRL) begin
               ctrl_out <= writedata_in[5:0];
               go_out <= writedata_in[`LCHP_CTRL_GO];
            end else if (address_in == `LCHP_REG_ADDR) begin
               addr_out <= writedata_in[16:0];
            end else if (address_in == `LCHP_REG_WDATA) begin
               wdata_out <= writedata_in[15:0];
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> src/lchp_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "lchp_defs.svh"
// How it works
// RULE1: Sixteen data lines, seventeen address lines to device.
// RULE2: Split mode: low/high write strobes per byte.
// RULE3: Split mode: low/high read strobes per byte.
// RULE4: This glue derives the four byte strobes.
// RULE5: Shared mode: high byte enable qualifies both.
// RULE6: Shared mode: one low write strobe.
// RULE7: Shared mode: one low read strobe.
// RULE8: Device holds wait low until data ready.
// RULE9: Device holds wait through refresh arbitration.
// RULE10: Host extends cycle while wait low; this host ends it at the LCHP_TMO_CYC timeout.
// RULE11: Bus status strap selects mode only.
// RULE12: Shared mode: high read strobe held high.
// RULE13: Endian strap driven steady through reset.
// RULE14: Byte lane order follows endian choice.
// RULE15: Chip select decoded over device window.
// RULE16: Host bus clock driven from own clock.
// RULE17: Bus clock runs in both modes.
// RULE18: Only memory and register ranges accessed.
// RULE19: Device synchronises strobes; sampling here too.
// RULE20: Strobes only under select; drive data writes.
module lchp_host (
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire logic CE_IN,
   input wire logic [3:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   output logic [16:0] HOST_ADDRESS_OUT,
   input wire logic [15:0] HOST_DATA_IN,
   output logic [15:0] HOST_DATA_OUT,
   output logic HOST_DATA_OE_OUT,
   output logic CHIP_SELECT_N_OUT,
   output logic LOW_WRITE_STROBE_N_OUT,
   output logic HIGH_BYTE_STROBE_N_OUT,
   output logic LOW_READ_STROBE_N_OUT,
   output logic HIGH_READ_STROBE_N_OUT,
   input wire logic WAIT_N_IN,
   output logic BUS_STATUS_STRAP_OUT,
   output logic ENDIAN_SELECT_STRAP_OUT,
   output logic [2:0] INTERFACE_SELECT_STRAPS_OUT,
   output logic HOST_BUS_CLOCK_OUT
);
   lchp_pkg::lchp_state_e state_ff;
   logic [5:0] ctrl;
   logic go;
   logic [16:0] req_addr;
   logic [15:0] req_wdata;
   logic [31:0] status;
   logic wait_n_s;
   logic busy_ff;
   logic done_ff;
   logic badadr_ff;
   logic tmo_ff;
   logic [15:0] rdata_ff;
   logic [3:0] cnt_ff;
   logic [15:0] tmo_ff_cnt;
   logic op_read_ff;
   logic op_lo_ff;
   logic op_hi_ff;
   logic shared_ff;
   logic bigend_ff;
   logic [3:0] strap_cnt_ff;
   logic strap_hold_ff;

   // Address inside memory or register range of the device window
   function automatic logic addr_ok(input logic [16:0] a);
      addr_ok = (a <= `LCHP_MEM_TOP) || (a >= `LCHP_REG_BASE);
   endfunction

   // Byte swap for big-endian hosts
   function automatic logic [15:0] lane(input logic [15:0] d,
                                        input logic be);
      lane = be ? {d[7:0], d[15:8]} : d;
   endfunction

   assign status = {rdata_ff, 12'h000,
                    tmo_ff, badadr_ff, done_ff, busy_ff};

   lchp_avs u_avs (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .ce_in(CE_IN),
      .address_in(AVS_ADDRESS_IN),
      .read_in(AVS_READ_IN),
      .write_in(AVS_WRITE_IN),
      .writedata_in(AVS_WRITEDATA_IN),
      .readdata_out(AVS_READDATA_OUT),
      .waitrequest_out(AVS_WAITREQUEST_OUT),
      .status_in(status),
      .ctrl_out(ctrl),
      .go_out(go),
      .addr_out(req_addr),
      .wdata_out(req_wdata)
   );

   lchp_sync u_wait_sync (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .ce_in(CE_IN),
      .d_in(WAIT_N_IN),
      .init_in(1'b1),
      .q_out(wait_n_s)
   );

   // Divide own clock by two for the device bus clock, in either mode
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         HOST_BUS_CLOCK_OUT <= 1'b0;
      end else if (CE_IN) begin
         HOST_BUS_CLOCK_OUT <= ~HOST_BUS_CLOCK_OUT; // RULE16 RULE17
      end
   end

   // Bus status and endian straps follow ctrl whenever idle, even right after reset; go is held off for a few cycles after reset
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         strap_cnt_ff <= 4'h0;
         strap_hold_ff <= 1'b1;
         BUS_STATUS_STRAP_OUT <= 1'b0;
         ENDIAN_SELECT_STRAP_OUT <= 1'b0;
         INTERFACE_SELECT_STRAPS_OUT <= 3'h7;
      end else if (CE_IN) begin
         if (strap_cnt_ff != `LCHP_STRAP_CYC) begin
            strap_cnt_ff <= strap_cnt_ff + 4'h1;
         end else begin
            strap_hold_ff <= 1'b0;
         end
         // Strap changes take effect while idle and are latched at the start of the next transfer
         if (state_ff == lchp_pkg::ST_IDLE) begin
            BUS_STATUS_STRAP_OUT <= ctrl[`LCHP_CTRL_SHARED]; // RULE11
            ENDIAN_SELECT_STRAP_OUT <= ctrl[`LCHP_CTRL_BIGEND]; // RULE13
         end
      end
   end

   // Transfer sequencer
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         state_ff <= lchp_pkg::ST_IDLE;
         cnt_ff <= 4'h0;
         tmo_ff_cnt <= 16'h0000;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         badadr_ff <= 1'b0;
         tmo_ff <= 1'b0;
         rdata_ff <= 16'h0000;
         op_read_ff <= 1'b0;
         op_lo_ff <= 1'b0;
         op_hi_ff <= 1'b0;
         shared_ff <= 1'b0;
         bigend_ff <= 1'b0;
      end else if (CE_IN) begin
         case (state_ff)
            lchp_pkg::ST_IDLE: begin
               cnt_ff <= 4'h0;
               tmo_ff_cnt <= 16'h0000;
               if (go && !strap_hold_ff) begin
                  done_ff <= 1'b0;
                  tmo_ff <= 1'b0;
                  if (!addr_ok(req_addr)) begin
                     badadr_ff <= 1'b1; // RULE18
                     done_ff <= 1'b1;
                  end else begin
                     badadr_ff <= 1'b0;
                     busy_ff <= 1'b1;
                     op_read_ff <= ctrl[`LCHP_CTRL_READ];
                     op_lo_ff <= ctrl[`LCHP_CTRL_LO];
                     op_hi_ff <= ctrl[`LCHP_CTRL_HI];
                     shared_ff <= BUS_STATUS_STRAP_OUT;
                     bigend_ff <= ENDIAN_SELECT_STRAP_OUT; // RULE14
                     state_ff <= lchp_pkg::ST_SETUP;
                  end
               end
            end
            lchp_pkg::ST_SETUP: begin
               // Select settles before strobes
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_ff == 4'(`LCHP_SETUP_CYC - 1)) begin
                  cnt_ff <= 4'h0;
                  state_ff <= lchp_pkg::ST_STROBE;
               end
            end
            lchp_pkg::ST_STROBE: begin
               // Cover the wait synchroniser latency, so a late wait is seen
               cnt_ff <= cnt_ff + 4'h1;
               tmo_ff_cnt <= tmo_ff_cnt + 16'h0001;
               if (tmo_ff_cnt == `LCHP_TMO_CYC) begin
                  tmo_ff <= 1'b1;
                  state_ff <= lchp_pkg::ST_HOLD;
               end else if (cnt_ff >= 4'h5 && wait_n_s) begin
                  // RULE8 RULE9 RULE10 RULE19
                  if (op_read_ff) begin
                     rdata_ff <= lane(HOST_DATA_IN, bigend_ff);
                  end
                  state_ff <= lchp_pkg::ST_HOLD;
               end
            end
            lchp_pkg::ST_HOLD: begin
               cnt_ff <= 4'h0;
               state_ff <= lchp_pkg::ST_RECOV;
            end
            lchp_pkg::ST_RECOV: begin
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_ff == 4'(`LCHP_RECOV_CYC - 1)) begin
                  busy_ff <= 1'b0;
                  done_ff <= 1'b1;
                  state_ff <= lchp_pkg::ST_IDLE;
               end
            end
            default: begin
               state_ff <= lchp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Pin drive
   logic sel;
   logic strobe;
   assign sel = (state_ff != lchp_pkg::ST_IDLE) &&
                (state_ff != lchp_pkg::ST_RECOV);
   assign strobe = state_ff == lchp_pkg::ST_STROBE;

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         HOST_ADDRESS_OUT <= 17'h0_0000;
         HOST_DATA_OUT <= 16'h0000;
         HOST_DATA_OE_OUT <= 1'b0;
         CHIP_SELECT_N_OUT <= 1'b1;
         LOW_WRITE_STROBE_N_OUT <= 1'b1;
         HIGH_BYTE_STROBE_N_OUT <= 1'b1;
         LOW_READ_STROBE_N_OUT <= 1'b1;
         HIGH_READ_STROBE_N_OUT <= 1'b1;
      end else if (CE_IN) begin
         HOST_ADDRESS_OUT <= req_addr; // RULE1
         HOST_DATA_OUT <= lane(req_wdata, bigend_ff);
         HOST_DATA_OE_OUT <= sel && !op_read_ff; // RULE20
         CHIP_SELECT_N_OUT <= !sel; // RULE15
         if (!shared_ff) begin
            // RULE2 RULE3 RULE4
            LOW_WRITE_STROBE_N_OUT <= !(strobe && !op_read_ff && op_lo_ff);
            HIGH_BYTE_STROBE_N_OUT <= !(strobe && !op_read_ff && op_hi_ff);
            LOW_READ_STROBE_N_OUT <= !(strobe && op_read_ff && op_lo_ff);
            HIGH_READ_STROBE_N_OUT <= !(strobe && op_read_ff && op_hi_ff);
         end else begin
            LOW_WRITE_STROBE_N_OUT <= !(strobe && !op_read_ff); // RULE6
            HIGH_BYTE_STROBE_N_OUT <= !(sel && op_hi_ff); // RULE5
            LOW_READ_STROBE_N_OUT <= !(strobe && op_read_ff); // RULE7
            HIGH_READ_STROBE_N_OUT <= 1'b1; // RULE12
         end
      end
   end
endmodule
`default_nettype wire

// >>> verif/lchp_host_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module lchp_chk (
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire logic CE_IN,
   input wire logic CHIP_SELECT_N_OUT,
   input wire logic LOW_WRITE_STROBE_N_OUT,
   input wire logic HIGH_BYTE_STROBE_N_OUT,
   input wire logic LOW_READ_STROBE_N_OUT,
   input wire logic HIGH_READ_STROBE_N_OUT,
   input wire logic WAIT_N_IN,
   input wire logic HOST_DATA_OE_OUT,
   input wire logic BUS_STATUS_STRAP_OUT,
   input wire logic [16:0] HOST_ADDRESS_OUT,
   input wire logic HOST_BUS_CLOCK_OUT
);
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_B_IN);
   logic rd_lo, wr_lo, stb_lo;
   logic [12:0] stb_cnt_ff;
   assign rd_lo = !LOW_READ_STROBE_N_OUT || !HIGH_READ_STROBE_N_OUT;
   // Shared mode holds the byte enable for the whole select
   assign wr_lo = !LOW_WRITE_STROBE_N_OUT
      || (!BUS_STATUS_STRAP_OUT && !HIGH_BYTE_STROBE_N_OUT);
   assign stb_lo = rd_lo || wr_lo;
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         stb_cnt_ff <= 13'h0000;
      end else begin
         stb_cnt_ff <= stb_lo ? stb_cnt_ff + 13'h0001 : 13'h0000;
      end
   end
   a_strobe_cs: assert property (
      (stb_lo || !HIGH_BYTE_STROBE_N_OUT) |-> !CHIP_SELECT_N_OUT)
      else $error("strobe without select");
   a_shared_hrd: assert property (
      BUS_STATUS_STRAP_OUT |-> HIGH_READ_STROBE_N_OUT)
      else $error("high read strobe used in shared mode");
   a_drive_write: assert property (
      HOST_DATA_OE_OUT |-> !rd_lo && !CHIP_SELECT_N_OUT)
      else $error("data driven outside a write");
   a_setup_gap: assert property (
      $fell(CHIP_SELECT_N_OUT) |-> !stb_lo ##1 !stb_lo ##1 stb_lo)
      else $error("strobe not two cycles after select");
   a_strobe_min: assert property (
      $rose(stb_lo) |-> stb_lo [*4])
      else $error("strobe shorter than four cycles");
   a_wait_hold: assert property (
      stb_lo && !WAIT_N_IN && stb_cnt_ff < 13'h0FA0 |=> stb_lo)
      else $error("strobe ended while wait low");
   a_tmo_bound: assert property (
      stb_cnt_ff < 13'h1004)
      else $error("strobe outlived timeout");
   a_addr_steady: assert property (
      !CHIP_SELECT_N_OUT && $past(!CHIP_SELECT_N_OUT)
      |-> $stable(HOST_ADDRESS_OUT)) else $error("address moved");
   a_window_only: assert property (
      !CHIP_SELECT_N_OUT |-> (HOST_ADDRESS_OUT <= 17'h1_3FFF
      || HOST_ADDRESS_OUT >= 17'h1_FFE0)) else $error("address in gap");
   a_bus_clock: assert property (
      $past(RST_B_IN) && $past(CE_IN)
      |-> HOST_BUS_CLOCK_OUT != $past(HOST_BUS_CLOCK_OUT))
      else $error("bus clock stopped");
endmodule
bind lchp_host lchp_chk u_chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
   .CE_IN(CE_IN), .CHIP_SELECT_N_OUT(CHIP_SELECT_N_OUT),
   .LOW_WRITE_STROBE_N_OUT(LOW_WRITE_STROBE_N_OUT),
   .HIGH_BYTE_STROBE_N_OUT(HIGH_BYTE_STROBE_N_OUT),
   .LOW_READ_STROBE_N_OUT(LOW_READ_STROBE_N_OUT),
   .HIGH_READ_STROBE_N_OUT(HIGH_READ_STROBE_N_OUT),
   .WAIT_N_IN(WAIT_N_IN), .HOST_DATA_OE_OUT(HOST_DATA_OE_OUT),
   .BUS_STATUS_STRAP_OUT(BUS_STATUS_STRAP_OUT),
   .HOST_ADDRESS_OUT(HOST_ADDRESS_OUT),
   .HOST_BUS_CLOCK_OUT(HOST_BUS_CLOCK_OUT));
`default_nettype wire

// >>> verif/lchp_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module lchp_dev_model (
   input wire logic bclk_in,
   input wire logic rst_b_in,
   input wire logic [4:0] ctl_in,
   input wire logic bs_in,
   input wire logic [16:0] addr_in,
   input wire logic [15:0] data_in,
   input wire logic [12:0] slow_in,
   output logic [15:0] data_out,
   output logic wait_n_out,
   output logic [7:0] acc_cnt_out
);
   logic [4:0] s1_ff, s2_ff;
   logic act_ff, rdy_ff, wr, lo, hi;
   logic [12:0] dly_ff;
   logic [15:0] mem [0:255];
   logic [7:0] a;
   // Strobes arrive already derived by the controller glue
   function automatic logic sel_f(input logic [4:0] v);
      return !v[4] && (!v[3] || !v[1] || (!bs_in && (!v[2] || !v[0])));
   endfunction
   assign a = addr_in[8:1];
   assign wr = !s2_ff[3] || (!bs_in && !s2_ff[2]);
   assign lo = bs_in ? !addr_in[0] : (!s2_ff[3] || !s2_ff[1]);
   assign hi = bs_in ? !s2_ff[2] : (!s2_ff[2] || !s2_ff[0]);
   // Raw strobes drop wait; the slow bus clock would answer too late
   assign wait_n_out = sel_f(ctl_in) ? rdy_ff : 1'b1;
   always_ff @(posedge bclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s1_ff <= 5'h1F;
         s2_ff <= 5'h1F;
         act_ff <= 1'b0;
         rdy_ff <= 1'b0;
         dly_ff <= 13'h0000;
         acc_cnt_out <= 8'h00;
         data_out <= 16'h0000;
      end else begin
         s1_ff <= ctl_in;
         s2_ff <= s1_ff;
         // Only a ready read keeps the last word; otherwise data_out toggles each bus clock
         data_out <= (rdy_ff && !wr) ? data_out : ~data_out;
         if (!sel_f(s2_ff)) begin
            act_ff <= 1'b0;
            rdy_ff <= 1'b0;
         end else if (!act_ff) begin
            act_ff <= 1'b1;
            dly_ff <= slow_in;
            acc_cnt_out <= acc_cnt_out + 8'h01;
         end else if (dly_ff != 13'h0000) begin
            dly_ff <= dly_ff - 13'h0001;
         end else if (!rdy_ff) begin
            rdy_ff <= 1'b1;
            data_out <= mem[a];
            if (wr && lo) mem[a][7:0] <= data_in[7:0];
            if (wr && hi) mem[a][15:8] <= data_in[15:8];
         end
      end
   end
endmodule
`default_nettype wire

// >>> verif/test_lchp_host.sv
`timescale 1ns/10ps
`default_nettype none
module test_lchp_host;
   logic clk, rst_b, ce, rd, wr, wreq, oe, cs_n, lwr_n, hbs_n, lrd_n;
   logic hrd_n, wait_n, bs, endian, bclk;
   logic [2:0] isel;
   logic [3:0] adr;
   logic [31:0] wdat, rdat, s;
   logic [16:0] haddr;
   logic [15:0] hout, dout, hin;
   logic [12:0] slow;
   logic [7:0] acc, n0;
   int fail_count, total_checks, cyc;
   assign hin = oe ? hout : dout;
   lchp_host dut (.CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce),
      .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
      .AVS_WRITEDATA_IN(wdat), .AVS_READDATA_OUT(rdat),
      .AVS_WAITREQUEST_OUT(wreq), .HOST_ADDRESS_OUT(haddr),
      .HOST_DATA_IN(hin), .HOST_DATA_OUT(hout), .HOST_DATA_OE_OUT(oe),
      .CHIP_SELECT_N_OUT(cs_n), .LOW_WRITE_STROBE_N_OUT(lwr_n),
      .HIGH_BYTE_STROBE_N_OUT(hbs_n), .LOW_READ_STROBE_N_OUT(lrd_n),
      .HIGH_READ_STROBE_N_OUT(hrd_n), .WAIT_N_IN(wait_n),
      .BUS_STATUS_STRAP_OUT(bs), .ENDIAN_SELECT_STRAP_OUT(endian),
      .INTERFACE_SELECT_STRAPS_OUT(isel), .HOST_BUS_CLOCK_OUT(bclk));
   lchp_dev_model u_dev (.bclk_in(bclk), .rst_b_in(rst_b),
      .ctl_in({cs_n, lwr_n, hbs_n, lrd_n, hrd_n}), .bs_in(bs),
      .addr_in(haddr), .data_in(hin), .slow_in(slow), .data_out(dout),
      .wait_n_out(wait_n), .acc_cnt_out(acc));
   task automatic check(input string n, input logic [31:0] v, e);
      total_checks++;
      if (v !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, v);
         fail_count++;
      end
   endtask
   task automatic av(input logic [3:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do @(posedge clk); while (wreq !== 1'b0);
      r = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic xfer(input logic [16:0] a, input logic [15:0] d,
      input logic [5:0] c, output logic [31:0] r);
      av(4'h4, 1'b1, {15'h0000, a}, r);
      av(4'h8, 1'b1, {16'h0000, d}, r);
      av(4'h0, 1'b1, {26'h000_0000, c & 6'h3E}, r);
      av(4'h0, 1'b1, {26'h000_0000, c}, r);
      do av(4'hC, 1'b0, 32'h0000_0000, r); while (r[0] !== 1'b0);
   endtask
   task automatic t_reset;
      check("straps", {28'h000_0000, isel, bs}, 32'h0000_000E);
      check("endian", {31'h0000_0000, endian}, 32'h0000_0000);
      av(4'h2, 1'b0, 32'h0000_0000, s);
      check("unmapped", s, 32'h0000_0000);
      $display("test reset done");
   endtask
   task automatic t_split;
      xfer(17'h0_0010, 16'h00AB, 6'h05, s);
      check("wr_status", s & 32'h0000_000F, 32'h0000_0002);
      xfer(17'h0_0010, 16'hCD00, 6'h09, s);
      xfer(17'h0_0010, 16'h0000, 6'h0F, s);
      check("split_rd", s, 32'hCDAB_0002);
      $display("test split done");
   endtask
   task automatic t_shared;
      xfer(17'h1_FFE0, 16'h5678, 6'h1D, s);
      check("shared_bs", {31'h0000_0000, bs}, 32'h0000_0001);
      xfer(17'h1_FFE0, 16'h0000, 6'h1F, s);
      check("shared_rd", s, 32'h5678_0002);
      $display("test shared done");
   endtask
   task automatic t_endian;
      xfer(17'h0_0020, 16'h9ABC, 6'h2D, s);
      check("big_strap", {31'h0000_0000, endian}, 32'h0000_0001);
      xfer(17'h0_0020, 16'h0000, 6'h2F, s);
      check("big_rd", s, 32'h9ABC_0002);
      xfer(17'h0_0020, 16'h0000, 6'h0F, s);
      check("little_rd", s, 32'hBC9A_0002);
      $display("test endian done");
   endtask
   task automatic t_slow;
      n0 = acc;
      slow <= 13'h0028;
      xfer(17'h0_0030, 16'hBEEF, 6'h0D, s);
      xfer(17'h0_0030, 16'h0000, 6'h0F, s);
      check("slow_rd", s, 32'hBEEF_0002);
      check("slow_cnt", {24'h00_0000, acc - n0}, 32'h0000_0002);
      slow <= 13'h0000;
      $display("test slow done");
   endtask
   task automatic t_bad;
      n0 = acc;
      xfer(17'h1_4000, 16'h1111, 6'h0D, s);
      check("bad_flag", s & 32'h0000_0005, 32'h0000_0004);
      check("bad_none", {24'h00_0000, acc}, {24'h00_0000, n0});
      $display("test bad address done");
   endtask
   task automatic t_tmo;
      slow <= 13'h0834;
      xfer(17'h0_0040, 16'h2222, 6'h0D, s);
      check("tmo_flag", s & 32'h0000_0009, 32'h0000_0008);
      slow <= 13'h0000;
      $display("test timeout done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Longest test waits about 4096 cycles on the strobe, until the host timeout
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         results();
      end
   end
   initial begin
      rst_b = 1'b0;
      cyc = 0;
      ce = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      adr = 4'h0;
      wdat = 32'h0000_0000;
      slow = 13'h0000;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      t_reset();
      t_split();
      t_shared();
      t_endian();
      t_slow();
      t_bad();
      t_tmo();
      results();
   end
endmodule
`default_nettype wire
